// ===== event_timer_params.svh
// Register map, field positions and timing constants of the event timer.
// Assumes inclusion by bare name from the tick prescaler and event timer modules.
`ifndef EVENT_TIMER_PARAMS_SVH
`define EVENT_TIMER_PARAMS_SVH

`define ADDR_AUX_STATUS      6'h05
`define ADDR_COMMAND_CTRL    6'h09
`define ADDR_TIMER_COUNT     6'h0C
`define ADDR_TICK_DIV_CFG    6'h2A
`define ADDR_TICK_EVT_SEL    6'h2B
`define ADDR_COUNT_PRELOAD   6'h2C

`define BIT_COUNTING_FLAG    7
`define BIT_START_NOW        1
`define BIT_HALT_NOW         2
`define BIT_AUTO_RELOAD      5
`define FLD_DIV_EXP_HI       4
`define BIT_START_TX_FIRST   0
`define BIT_START_TX_LAST    1
`define BIT_HALT_RX_FIRST    2
`define BIT_HALT_RX_LAST     3

`define RST_TICK_DIV_CFG     8'h00
`define RST_TICK_EVT_SEL     8'h00
`define RST_COUNT_PRELOAD    8'h00
`define DIV_EXP_MAX          5'h15
`define DIV_CNT_W            21

`endif

// ===== event_timer_pkg.sv
// Types shared by the event timer modules.
// Assumes nothing beyond the params header.
package event_timer_pkg;
   typedef enum logic [0:0]
   {
      TIMER_IDLE = 1'b0,
      TIMER_RUN  = 1'b1
   } timer_state_t;
endpackage : event_timer_pkg

// ===== tick_prescaler.sv
// Power-of-two tick divider: one-cycle enable every 2^exp clocks.
// Assumes the exponent is held stable by the register file.
`timescale 1ns/10ps
`include "event_timer_params.svh"

module tick_prescaler
   import event_timer_pkg::*;
#(
   parameter int CNT_W = `DIV_CNT_W
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       restart,
   input  wire logic [4:0] divExp,
   output logic            tick
);
   logic [CNT_W-1:0] div_reg;
   logic [CNT_W-1:0] div_next;
   logic [CNT_W-1:0] divMask;
   logic [4:0]       expClamped;

   always_comb
   begin
      // Exponents above the limit are clamped to the slowest rate
      expClamped = (divExp > `DIV_EXP_MAX) ? `DIV_EXP_MAX : divExp;
      divMask    = CNT_W'((64'h1 << expClamped) - 64'h1);
      tick       = ((div_reg & divMask) == divMask);
      div_next   = restart ? '0 : div_reg + CNT_W'(1);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= '0;
      else
         div_reg <= div_next;
   end
endmodule : tick_prescaler

// ===== event_timer.sv
// Event timer: 8-bit down counter with prescaler, start/stop events and irq flag.
// Assumes event strobes are single-cycle pulses on clk_sys; register port is
// a simple synchronous address/strobe port at the documented offsets.
//
// How it works
// - Running with nonzero count, decrement once per tick.
// - Auto reload loads preload on the tick where count is one.
// - Enabled tx events or software start copy preload into the counter.
// - Every start event without a stop event in the same cycle retriggers, even while already running.
// - Enabled rx events, expiry without reload, or software stop halt counting.
// - Preload or configuration writes never touch the running count.
// - Software stop never sets the expiry flag.
// - Reaching zero without a stop event raises the expiry flag.
// - Receive-side stop before expiry raises no flag.
// - Tick is clock divided by two to the exponent, zero to 21.
// - Start sets the counting flag, stop clears it.
// - Count readback follows the counter every tick while running.
// - With auto reload, one flag per period, reloading every time.
// - Flag sets on one-to-zero, or one-to-preload with auto reload.
// - Flag ANDed with its enable feeds the shared interrupt OR.
`timescale 1ns/10ps
`include "event_timer_params.svh"

module event_timer
   import event_timer_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [5:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       tx_first_bit_evt,
   input  wire logic       tx_last_bit_evt,
   input  wire logic       rx_first_bit_evt,
   input  wire logic       rx_last_bit_evt,
   input  wire logic       irqClear,
   input  wire logic       timerIrqEn,
   input  wire logic       otherIrqs,
   output logic            count_expired_irq,
   output logic            irqOut
);
   timer_state_t state_reg;
   timer_state_t state_next;
   logic [7:0]   count_reg;
   logic [7:0]   count_next;
   logic [7:0]   divCfg_reg;
   logic [7:0]   divCfg_next;
   logic [7:0]   evtSel_reg;
   logic [7:0]   evtSel_next;
   logic [7:0]   preload_reg;
   logic [7:0]   preload_next;
   logic         irq_reg;
   logic         irq_next;
   logic [7:0]   rdata_reg;
   logic [7:0]   rdata_next;
   logic         tick;
   logic         startEvt;
   logic         haltEvt;
   logic         swStart;
   logic         swHalt;
   logic         autoReload;
   logic         expire;
   logic [3:0]   evtIn;
   logic [3:0]   evtHit;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
      hit = (a == target);
   endfunction : hit

   tick_prescaler #(
      .CNT_W (`DIV_CNT_W)
   ) u_prescaler (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .restart (startEvt),
      .divExp  (divCfg_reg[`FLD_DIV_EXP_HI:0]),
      .tick    (tick)
   );

   // Event pins in the same bit order as the event select register
   assign evtIn = {rx_last_bit_evt, rx_first_bit_evt, tx_last_bit_evt, tx_first_bit_evt};

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_evt_gate
         assign evtHit[i] = evtIn[i] && evtSel_reg[i];
      end
   endgenerate

   always_comb
   begin
      autoReload = divCfg_reg[`BIT_AUTO_RELOAD];
      // Strobes exist only in the write cycle, nothing stays latched
      swStart = regWrite && hit(regAddr, `ADDR_COMMAND_CTRL)
                && regWdata[`BIT_START_NOW];
      swHalt  = regWrite && hit(regAddr, `ADDR_COMMAND_CTRL)
                && regWdata[`BIT_HALT_NOW];
      startEvt = swStart
                 || evtHit[`BIT_START_TX_FIRST]
                 || evtHit[`BIT_START_TX_LAST];
      haltEvt  = swHalt
                 || evtHit[`BIT_HALT_RX_FIRST]
                 || evtHit[`BIT_HALT_RX_LAST];
      // Expiry only counts if no stop or start event lands in the same cycle
      expire = (state_reg == TIMER_RUN) && tick && (count_reg == 8'h01)
               && !haltEvt && !startEvt;
   end

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      unique case (state_reg)
         TIMER_IDLE:
         begin
            if (startEvt && !haltEvt)
            begin
               state_next = TIMER_RUN;
               count_next = preload_reg;
            end
         end
         TIMER_RUN:
         begin
            if (haltEvt)
               state_next = TIMER_IDLE;
            else if (startEvt)
               count_next = preload_reg;
            else if (tick)
            begin
               if (count_reg == 8'h01 && autoReload)
                  count_next = preload_reg;
               else if (count_reg == 8'h01)
               begin
                  count_next = 8'h00;
                  state_next = TIMER_IDLE;
               end
               else if (count_reg != 8'h00)
                  count_next = count_reg - 8'h01;
               else
                  state_next = TIMER_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= TIMER_IDLE;
         count_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   always_comb
   begin
      // Config writes only reach the registers, never the count
      divCfg_next  = divCfg_reg;
      evtSel_next  = evtSel_reg;
      preload_next = preload_reg;
      if (regWrite)
      begin
         if (hit(regAddr, `ADDR_TICK_DIV_CFG))
            divCfg_next = {2'b00, regWdata[5:0]};
         if (hit(regAddr, `ADDR_TICK_EVT_SEL))
            evtSel_next = {4'h0, regWdata[3:0]};
         if (hit(regAddr, `ADDR_COUNT_PRELOAD))
            preload_next = regWdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCfg_reg  <= `RST_TICK_DIV_CFG;
         evtSel_reg  <= `RST_TICK_EVT_SEL;
         preload_reg <= `RST_COUNT_PRELOAD;
      end
      else
      begin
         divCfg_reg  <= divCfg_next;
         evtSel_reg  <= evtSel_next;
         preload_reg <= preload_next;
      end
   end

   always_comb
   begin
      // Set wins over a clear in the same cycle
      irq_next = expire ? 1'b1 : (irqClear ? 1'b0 : irq_reg);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_next;
   end

   always_comb
   begin
      rdata_next = rdata_reg;
      if (regRead)
      begin
         if (hit(regAddr, `ADDR_AUX_STATUS))
            rdata_next = {(state_reg == TIMER_RUN), 7'h00};
         else if (hit(regAddr, `ADDR_TIMER_COUNT))
            rdata_next = count_reg;
         else if (hit(regAddr, `ADDR_TICK_DIV_CFG))
            rdata_next = divCfg_reg;
         else if (hit(regAddr, `ADDR_TICK_EVT_SEL))
            rdata_next = evtSel_reg;
         else if (hit(regAddr, `ADDR_COUNT_PRELOAD))
            rdata_next = preload_reg;
         else
            rdata_next = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end

   assign regRdata          = rdata_reg;
   assign count_expired_irq = irq_reg;
   assign irqOut            = (irq_reg && timerIrqEn) || otherIrqs;
endmodule : event_timer

// ===== timer_monitor.sv
// Concurrent checks on the event timer register port and flag outputs.
// Assumes a bind onto event_timer, one clock, async active-low reset.
`timescale 1ns/10ps
module timer_monitor
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic [5:0] regAddr,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic       irqClear,
   input wire logic       timerIrqEn,
   input wire logic       otherIrqs,
   input wire logic       count_expired_irq,
   input wire logic       irqOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_irq_combine: assert property (
      irqOut == ((count_expired_irq && timerIrqEn) || otherIrqs)) else $error("irq mix wrong");
   a_flag_sticky: assert property (
      count_expired_irq && !irqClear |=> count_expired_irq) else $error("flag dropped");
   a_halt_no_flag: assert property (
      regWrite && regAddr == 6'h09 && regWdata[2] && !count_expired_irq |=> !count_expired_irq)
      else $error("flag on halt");
   a_halt_clears_run: assert property (
      regWrite && regAddr == 6'h09 && regWdata[2] ##1 regRead && regAddr == 6'h05
      |=> !regRdata[7]) else $error("still running after halt");
   a_start_sets_run: assert property (
      regWrite && regAddr == 6'h09 && regWdata[2:1] == 2'b01 ##1 regRead && regAddr == 6'h05
      |=> regRdata[7]) else $error("not running after start");
   a_preload_back: assert property (
      regWrite && regAddr == 6'h2C ##1 regRead && regAddr == 6'h2C
      |=> regRdata == $past(regWdata, 2)) else $error("preload readback");
   a_evt_sel_mask: assert property (
      regWrite && regAddr == 6'h2B ##1 regRead && regAddr == 6'h2B
      |=> regRdata == {4'h0, $past(regWdata[3:0], 2)}) else $error("event select readback");
   a_read_holds: assert property (
      !regRead |=> $stable(regRdata)) else $error("read data moved");
endmodule : timer_monitor

// ===== test_event_timer.sv
// Self-checking bench for the event timer: registers, events and expiry flag.
// Assumes read data is valid just after the edge that takes the read.
`timescale 1ns/10ps
module test_event_timer;
   logic       clk_sys = 0;
   logic       rst_n = 0;
   logic [5:0] regAddr = 0;
   logic       regWrite = 0, regRead = 0;
   logic [7:0] regWdata = 0, regRdata, rv;
   logic       txF = 0, txL = 0, rxF = 0, rxL = 0, irqClear = 0, timerIrqEn = 1, otherIrqs = 0;
   logic       irq, irqOut;
   int         fail_count = 0, n_compared = 0, cyc = 0;
   time        wrEnd = 0, rdEnd = 0;
   event_timer dut (.clk_sys, .rst_n, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
      .tx_first_bit_evt(txF), .tx_last_bit_evt(txL), .rx_first_bit_evt(rxF),
      .rx_last_bit_evt(rxL), .irqClear, .timerIrqEn, .otherIrqs,
      .count_expired_irq(irq), .irqOut);
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      // Let an edge pass so a strobe is never lowered and raised in one step
      if (wrEnd == $time)
         step();
      regAddr = a;
      regWdata = d;
      regWrite = 1;
      step();
      regWrite = 0;
      wrEnd = $time;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      if (rdEnd == $time)
         step();
      regAddr = a;
      regRead = 1;
      step();
      regRead = 0;
      rv = regRdata;
      rdEnd = $time;
   endtask : rd
   task automatic pulse(ref logic s);
      s = 1;
      step();
      s = 0;
   endtask : pulse
   // Bounded so a flag that never comes ends as a mismatch, not a hang
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 3000)
      begin
         step();
         n++;
      end
   endtask : wait_irq
   task automatic t_reset();
      rd(6'h05);
      chk(rv[7], 0, "idle after reset");
      rd(6'h3F);
      chk(rv, 0, "unmapped read");
      wr(6'h2B, 8'hFF);
      rd(6'h2B);
      chk(rv, 8'h0F, "event select bits");
      otherIrqs = 1;
      step();
      chk(irqOut, 1, "other irq passes");
      otherIrqs = 0;
      $display("t_reset done");
   endtask : t_reset
   task automatic t_oneshot();
      int n;
      wr(6'h2B, 8'h00);
      wr(6'h2A, 8'h02);
      wr(6'h2C, 8'h03);
      wr(6'h09, 8'h02);
      wait_irq(n);
      chk(n >= 11 && n <= 13, 1, "expiry time");
      chk(irqOut, 1, "irq out");
      rd(6'h0C);
      chk(rv, 0, "count at expiry");
      rd(6'h05);
      chk(rv[7], 0, "stops at zero");
      pulse(irqClear);
      chk(irq, 0, "flag cleared");
      $display("t_oneshot done");
   endtask : t_oneshot
   task automatic t_periodic();
      int n;
      wr(6'h2A, 8'h20);
      wr(6'h2C, 8'h08);
      wr(6'h09, 8'h02);
      wait_irq(n);
      pulse(irqClear);
      wait_irq(n);
      chk(n >= 5 && n <= 8, 1, "reload period");
      rd(6'h05);
      chk(rv[7], 1, "still running");
      wr(6'h09, 8'h04);
      pulse(irqClear);
      repeat (20) step();
      chk(irq, 0, "no flag after halt");
      $display("t_periodic done");
   endtask : t_periodic
   task automatic t_events();
      wr(6'h2A, 8'h05);
      wr(6'h2C, 8'hC8);
      wr(6'h2B, 8'h0A);
      pulse(txL);
      rd(6'h05);
      chk(rv[7], 1, "tx start");
      wr(6'h2C, 8'h05);
      rd(6'h2C);
      chk(rv, 8'h05, "preload readback");
      rd(6'h0C);
      chk(rv, 8'hC8, "count kept");
      pulse(rxL);
      rd(6'h05);
      chk(rv[7], 0, "rx stop");
      chk(irq, 0, "no flag on rx stop");
      wr(6'h2B, 8'h05);
      pulse(txL);
      rd(6'h05);
      chk(rv[7], 0, "disabled start");
      pulse(txF);
      rd(6'h05);
      chk(rv[7], 1, "tx first start");
      pulse(rxF);
      rd(6'h05);
      chk(rv[7], 0, "rx first stop");
      wr(6'h09, 8'h06);
      rd(6'h05);
      chk(rv[7], 0, "stop beats start");
      $display("t_events done");
   endtask : t_events
   task automatic t_stopwatch();
      wr(6'h2A, 8'h00);
      wr(6'h2B, 8'h08);
      wr(6'h2C, 8'hC8);
      wr(6'h09, 8'h02);
      rd(6'h05);
      chk(rv[7], 1, "software start");
      repeat (5) step();
      wr(6'h09, 8'h02);
      repeat (10) step();
      pulse(rxL);
      rd(6'h0C);
      // Retrigger and stop edges lie 11 edges apart: 10 ticks between them
      chk(rv, 8'hBE, "count after retrigger");
      chk(8'hC8 - rv, 8'h0A, "elapsed ticks");
      $display("t_stopwatch done");
   endtask : t_stopwatch
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1;
      t_reset();
      t_oneshot();
      t_periodic();
      t_events();
      t_stopwatch();
      report_and_stop();
   end
endmodule : test_event_timer
bind event_timer timer_monitor mon (.clk_sys, .rst_n, .regAddr, .regWrite, .regRead,
   .regWdata, .regRdata, .irqClear, .timerIrqEn, .otherIrqs, .count_expired_irq, .irqOut);
